// file: test/i2c_master_model.sv
`timescale 1ns/10ps
module i2c_master_model
   import conv_pkg::*;
(
   input  wire logic i_lclk,
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda,
   output logic      o_rd_stb,
   output byte_t     o_rd_data
);
   initial
   begin
      o_scl = 1'b1;
      o_sda = 1'b1;
      o_rd_stb = 1'b0;
      o_rd_data = 8'h00;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge i_lclk);
   endtask : tick

   // also serves as repeated start when entered with scl low
   task automatic start();
      tick(1);
      o_sda <= 1'b1;
      tick(1);
      o_scl <= 1'b1;
      tick(2);
      o_sda <= 1'b0;
      tick(2);
      o_scl <= 1'b0;
   endtask : start

   task automatic stop();
      tick(1);
      o_sda <= 1'b0;
      tick(1);
      o_scl <= 1'b1;
      tick(2);
      o_sda <= 1'b1;
      tick(2);
   endtask : stop

   // data moves only with scl low; sampled mid high phase
   task automatic clk_bit(input logic b, output logic s);
      tick(1);
      o_sda <= b;
      tick(1);
      o_scl <= 1'b1;
      tick(1);
      s = i_sda;
      tick(1);
      o_scl <= 1'b0;
   endtask : clk_bit

   task automatic send(input byte_t b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         clk_bit(b[i], s);
      clk_bit(1'b1, ack);
   endtask : send

   task automatic recv(input logic ack, output byte_t b);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         clk_bit(1'b1, s);
         b[i] = s;
      end
      o_rd_data <= b;
      clk_bit(ack, s);
      o_rd_stb <= 1'b1;
      tick(1);
      o_rd_stb <= 1'b0;
   endtask : recv
endmodule : i2c_master_model

// file: test/tb.sv
`timescale 1ns/10ps
`include "conv_defs.svh"
module tb
   import conv_pkg::*;
;
   logic       mclk = 1'b0;
   logic       lclk = 1'b0;
   logic       rst = 1'b1;
   logic       strap = 1'b1;
   logic       en = 1'b1;
   logic [4:0] flg = 5'h00;
   logic       scl;
   logic       m_sda;
   logic       sda_wire;
   logic       rd_stb;
   byte_t      rd_data;
   logic       sda_out;
   logic       sda_oe_n;
   logic       conv_on;
   logic       loop_sel;
   ref_code_t  ref_code;
   logic [2:0] slew;
   logic [1:0] freq;
   logic       forced_continuous_mode;
   logic [6:0] dev_addr = `ADDR_DEFAULT;
   byte_t      exp_q[$];
   int         n_mismatch = 0;
   int         tests_run = 0;
   logic [15:0] rnd = 16'(42984);
   byte_t      d;
   int         n;

   always #2.5 mclk = ~mclk;
   // link clock kept off phase from the system clock
   initial
   begin
      #3.1;
      forever #16 lclk = ~lclk;
   end

   // open drain wire with pull-up
   assign sda_wire = m_sda & (sda_oe_n | sda_out);

   conv_i2c_ctrl uut (
      .I_MCLK                    (mclk),
      .I_SYS_RST                 (rst),
      .I_CE                      (1'b1),
      .I_SCL                     (scl),
      .I_SDA                     (sda_wire),
      .I_ADDR_STRAP_PIN          (strap),
      .I_ENABLE_PIN              (en),
      .I_SCALING_DONE_FLAG       (flg[4]),
      .I_OVERCURRENT_HICCUP_FLAG (flg[3]),
      .I_THERMAL_EARLY_WARNING   (flg[2]),
      .I_THERMAL_SHUTDOWN_FLAG   (flg[1]),
      .I_POWER_GOOD_FLAG         (flg[0]),
      .O_SDA_OUT                 (sda_out),
      .O_SDA_OE_N                (sda_oe_n),
      .O_CONVERTER_ON            (conv_on),
      .O_DIVIDER_LOOP_SEL        (loop_sel),
      .O_REF_CODE                (ref_code),
      .O_SLEW_SEL                (slew),
      .O_FREQ_SEL                (freq),
      .O_FORCED_CONTINUOUS_MODE  (forced_continuous_mode)
   );

   i2c_master_model m (
      .i_lclk    (lclk),
      .i_sda     (sda_wire),
      .o_scl     (scl),
      .o_sda     (m_sda),
      .o_rd_stb  (rd_stb),
      .o_rd_data (rd_data)
   );

   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction : lfsr

   task automatic report_and_stop();
      if (n_mismatch == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop

   task automatic cmp_bit(input logic got, input logic exp);
      tests_run++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("Error at %0t: bit got %b expected %b", $time, got, exp);
      end
   endtask : cmp_bit

   task automatic cmp_byte(input byte_t got, input byte_t exp);
      tests_run++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("Error at %0t: byte got %h expected %h", $time, got, exp);
      end
   endtask : cmp_byte

   always @(posedge rd_stb)
      cmp_byte(rd_data, exp_q.pop_front());

   task automatic wr(input logic [6:0] dv, input byte_t r, input byte_t v, input logic na);
      logic a;
      m.start();
      m.send({dv, 1'b0}, a);
      cmp_bit(a, na);
      m.send(r, a);
      cmp_bit(a, na);
      m.send(v, a);
      cmp_bit(a, na);
      m.stop();
   endtask : wr

   task automatic rd(input byte_t r, input byte_t e);
      logic  a;
      byte_t b;
      exp_q.push_back(e);
      m.start();
      m.send({dev_addr, 1'b0}, a);
      m.send(r, a);
      m.start();
      m.send({dev_addr, 1'b1}, a);
      cmp_bit(a, 1'b0);
      m.recv(1'b1, b);
      m.stop();
   endtask : rd

   // bounded wait for the ramp to land; n returns cycles spent
   task automatic wait_code(input ref_code_t t, output int c);
      c = 0;
      while (ref_code !== t && c < 4000)
      begin
         @(negedge mclk);
         c++;
      end
      if (c >= 4000)
      begin
         n_mismatch++;
         report_and_stop();
      end
   endtask : wait_code

   initial
   begin
      #400000;
      n_mismatch++;
      report_and_stop();
   end

   initial
   begin
      repeat (20) @(negedge mclk);
      rst = 1'b0;
      repeat (8) @(negedge mclk);
      cmp_bit(conv_on, 1'b1);
      cmp_bit(loop_sel, 1'b1);
      cmp_byte(byte_t'(ref_code), 8'h00);
      cmp_byte(byte_t'(slew), 8'h04);
      cmp_byte(byte_t'(freq), 8'h00);
      cmp_bit(forced_continuous_mode, 1'b1);
      cmp_bit(sda_out, 1'b0);
      rd(`VOLT_SEL_OFS, 8'h80);
      rd(`CTRL_OFS, 8'hA1);
      rd(`IDENT_OFS, {`VENDOR_CODE, `REVISION_CODE});
      rd(8'h04, 8'h00);
      for (int k = 0; k < 8; k++)
      begin
         rnd = lfsr(rnd);
         d = {rnd[7], 1'b0, 3'(k), 2'(k), rnd[0]};
         wr(dev_addr, `CTRL_OFS, d, 1'b0);
         repeat (4) @(negedge mclk);
         cmp_bit(conv_on, d[7]);
         cmp_byte(byte_t'(slew), byte_t'(d[5:3]));
         cmp_byte(byte_t'(freq), byte_t'(d[2:1]));
         cmp_bit(forced_continuous_mode, d[0]);
         rd(`CTRL_OFS, d);
      end
      for (int k = 0; k < 3; k++)
      begin
         rnd = lfsr(rnd);
         @(negedge mclk);
         flg = rnd[4:0];
         rd(`FAULT_OFS, {3'b000, rnd[4:0]});
      end
      // small step keeps the unlock bit set
      wr(dev_addr, `CTRL_OFS, 8'hC1, 1'b0);
      wr(dev_addr, `VOLT_SEL_OFS, 8'h03, 1'b0);
      wait_code(7'h03, n);
      cmp_bit(loop_sel, 1'b0);
      rd(`CTRL_OFS, 8'hC1);
      wr(dev_addr, `CTRL_OFS, 8'h81, 1'b0);
      // locked: code dropped, loop bit kept
      wr(dev_addr, `VOLT_SEL_OFS, 8'h17, 1'b0);
      rd(`VOLT_SEL_OFS, 8'h03);
      cmp_byte(byte_t'(ref_code), 8'h03);
      wr(dev_addr, `CTRL_OFS, 8'hC1, 1'b0);
      wr(dev_addr, `VOLT_SEL_OFS, 8'h97, 1'b0);
      cmp_bit(ref_code == 7'h17, 1'b0);
      cmp_bit(sda_out, 1'b0);
      wait_code(7'h17, n);
      cmp_bit(n >= 500 && n <= 640, 1'b1);
      cmp_bit(loop_sel, 1'b1);
      repeat (4) @(negedge mclk);
      rd(`CTRL_OFS, 8'h81);
      wr(dev_addr, `IDENT_OFS, 8'h00, 1'b0);
      rd(`IDENT_OFS, {`VENDOR_CODE, `REVISION_CODE});
      @(negedge mclk);
      strap = 1'b0;
      repeat (8) @(negedge mclk);
      wr(`ADDR_DEFAULT, `CTRL_OFS, 8'h00, 1'b1);
      dev_addr = `ADDR_STRAPPED;
      rd(`CTRL_OFS, 8'h81);
      @(negedge mclk);
      en = 1'b0;
      repeat (8) @(negedge mclk);
      cmp_bit(conv_on, 1'b0);
      wr(dev_addr, `CTRL_OFS, 8'h00, 1'b1);
      en = 1'b1;
      repeat (8) @(negedge mclk);
      cmp_bit(conv_on, 1'b1);
      rd(`CTRL_OFS, 8'hA1);
      repeat (8) @(negedge mclk);
      report_and_stop();
   end
endmodule : tb

// file: verilog/bit_sync.sv
`timescale 1ns/10ps
module bit_sync #(
   parameter int W = 1
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   input  wire logic         i_ce,
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);

   logic [W-1:0] meta_r;

   // first stage feeds only the second
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         meta_r <= '0;
         o_q    <= '0;
      end
      else if (i_ce)
      begin
         meta_r <= i_d;
         o_q    <= meta_r;
      end
   end

endmodule : bit_sync

// file: verilog/conv_defs.svh
`ifndef CONV_DEFS_SVH
`define CONV_DEFS_SVH

// slave addresses
`define ADDR_DEFAULT      7'h62
`define ADDR_STRAPPED     7'h6A

// register offsets
`define VOLT_SEL_OFS      8'h00
`define CTRL_OFS          8'h01
`define IDENT_OFS         8'h02
`define FAULT_OFS         8'h03

// reset values
`define VOLT_SEL_RST      8'h80
`define CTRL_RST          8'hA1

// field positions
`define LOOP_SEL_BIT      7
`define REF_CODE_HI       6
`define CONV_ON_BIT       7
`define UNLOCK_BIT        6
`define SLEW_HI           5
`define SLEW_LO           3
`define FREQ_HI           2
`define FREQ_LO           1
`define MODE_BIT          0

// arbitrary identification values
`define VENDOR_CODE       4'h5
`define REVISION_CODE     4'h1

// timing
`define MCLK_PERIOD_PS    5000
`define STEP_MV           10
`define SMALL_STEP_MV     50
`define SMALL_STEP_CODES  7'((`SMALL_STEP_MV) / (`STEP_MV))
`define SLEW_FASTEST_X2   128

`endif

// file: verilog/conv_i2c_ctrl.sv
`timescale 1ns/10ps
`include "conv_defs.svh"
// Operation
// (R1) answer address 0x62, or 0x6A when the strap pin is grounded
// (R2) sda changes only while scl low, one clock pulse per bit
// (R3) start is sda fall, stop is sda rise, both with scl high
// (R4) repeated start acts as start; busy until stop
// (R5) eight bits then an acknowledge slot driven low by the receiver
// (R6) first byte is seven address bits plus direction, 1 means read
// (R7) master writes address, register pointer, then one data byte
// (R8) device acknowledges every received byte once addressed
// (R9) data byte commits at the scl fall ending its last bit
// (R10) voltage select bit 7 picks divider loop (1) or sense pin (0)
// (R11) bits 6:0 give reference 0.6 V to 1.87 V in 10 mV steps
// (R12) control bit 7 turns converter on; enable pin low forces all off
// (R13) reference writes need unlock bit; it self-clears when change done
// (R14) changes within 50 mV leave unlock set for the host to clear
// (R15) control bits 5:3 pick slew, 64 down to 0.5 mV per us
// (R16) control bits 2:1 pick switching frequency 500k to 1.5 MHz
// (R17) control bit 0 low allows pulse-skip, high forces continuous
// (R18) identification gives vendor code high, revision low
// (R19) fault flag bits 7:5 read zero
// (R20) bit 4 shows output within 90 to 110 percent of reference
// (R21) bit 3 shows hiccup, bit 1 shows thermal shutdown
// (R22) bit 2 shows die above 120 C
// (R23) bit 0 shows output above 90 percent of target
// (R24) power good bit mirrors the power good pin
// (R25) reference ramps to a new code at the selected slew
// (R26) read: pointer write, repeated start, one byte, master nacks
// (R27) unmatched address gets no ack and sda stays released
module conv_i2c_ctrl
   import conv_pkg::*;
(
   input  wire logic       I_MCLK,
   input  wire logic       I_SYS_RST,
   input  wire logic       I_CE,
   input  wire logic       I_SCL,
   input  wire logic       I_SDA,
   input  wire logic       I_ADDR_STRAP_PIN,
   input  wire logic       I_ENABLE_PIN,
   input  wire logic       I_SCALING_DONE_FLAG,
   input  wire logic       I_OVERCURRENT_HICCUP_FLAG,
   input  wire logic       I_THERMAL_EARLY_WARNING,
   input  wire logic       I_THERMAL_SHUTDOWN_FLAG,
   input  wire logic       I_POWER_GOOD_FLAG,
   output logic            O_SDA_OUT,
   output logic            O_SDA_OE_N,
   output logic            O_CONVERTER_ON,
   output logic            O_DIVIDER_LOOP_SEL,
   output ref_code_t       O_REF_CODE,
   output logic [2:0]      O_SLEW_SEL,
   output logic [1:0]      O_FREQ_SEL,
   output logic            O_FORCED_CONTINUOUS_MODE
);

   logic [8:0]  pins_s;
   logic        scl_s;
   logic        sda_s;
   logic        strap_s;
   logic        en_s;
   logic        scl_q;
   logic        sda_q;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_c;
   logic        stop_c;
   logic        byte_end;
   logic        wr_commit;
   logic        ref_accept;
   logic        clr;
   logic [6:0]  my_addr;
   logic [6:0]  delta;
   link_state_e state_r;
   logic [3:0]  cnt_r;
   byte_t       shift_r;
   byte_t       ptr_r;
   byte_t       tx_r;
   byte_t       rd_byte;
   logic        rw_r;
   byte_t       volt_sel_r;
   byte_t       ctrl_r;
   byte_t       fault_r;
   logic        big_step_r;
   logic        ramp_done;

   bit_sync #(
      .W (9)
   ) u_pin_sync (
      .i_clk (I_MCLK),
      .i_rst (I_SYS_RST),
      .i_ce  (I_CE),
      .i_d   ({I_POWER_GOOD_FLAG, I_THERMAL_SHUTDOWN_FLAG, I_THERMAL_EARLY_WARNING,
               I_OVERCURRENT_HICCUP_FLAG, I_SCALING_DONE_FLAG, I_ENABLE_PIN,
               I_ADDR_STRAP_PIN, !I_SDA, !I_SCL}),
      .o_q   (pins_s)
   );

   // bus lines enter inverted so a cleared synchroniser reads idle high, no false edge
   assign scl_s   = !pins_s[0];
   assign sda_s   = !pins_s[1];
   assign strap_s = pins_s[2];
   assign en_s    = pins_s[3];

   // enable pin low shuts the serial side down and restores defaults
   assign clr = I_SYS_RST || !en_s; // R12

   always_ff @(posedge I_MCLK)
   begin
      if (I_SYS_RST)
      begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end
      else if (I_CE)
      begin
         scl_q <= scl_s;
         sda_q <= sda_s;
      end
   end

   assign scl_rise = scl_s && !scl_q;
   assign scl_fall = !scl_s && scl_q;
   assign start_c  = scl_s && scl_q && sda_q && !sda_s; // R3
   assign stop_c   = scl_s && scl_q && !sda_q && sda_s; // R3
   assign byte_end = scl_fall && (cnt_r == 4'h8); // R5
   assign my_addr  = strap_s ? `ADDR_DEFAULT : `ADDR_STRAPPED; // R1

   always_comb
   begin
      if (ptr_r == `VOLT_SEL_OFS)
         rd_byte = volt_sel_r;
      else if (ptr_r == `CTRL_OFS)
         rd_byte = ctrl_r;
      else if (ptr_r == `IDENT_OFS)
         rd_byte = {`VENDOR_CODE, `REVISION_CODE}; // R18
      else if (ptr_r == `FAULT_OFS)
         rd_byte = fault_r;
      else
         rd_byte = 8'h00;
   end

   // bit counter and receive shifter, sampled at scl rise
   always_ff @(posedge I_MCLK)
   begin
      if (clr)
      begin
         cnt_r   <= 4'h0;
         shift_r <= 8'h00;
      end
      else if (I_CE)
      begin
         if (start_c)
            cnt_r <= 4'h0;
         else if (scl_rise && cnt_r != 4'h8 && (state_r == ST_ADDR || state_r == ST_REG
                  || state_r == ST_DATA || state_r == ST_TX))
         begin
            shift_r <= {shift_r[6:0], sda_s}; // R6
            cnt_r   <= cnt_r + 4'h1;
         end
         else if (scl_fall && (state_r == ST_ADDR_ACK || state_r == ST_REG_ACK
                  || state_r == ST_DATA_ACK || state_r == ST_TX_ACK))
            cnt_r <= 4'h0;
      end
   end

   // sda only moves just after a detected scl fall
   always_ff @(posedge I_MCLK)
   begin
      if (clr)
      begin
         state_r    <= ST_IDLE;
         ptr_r      <= 8'h00;
         tx_r       <= 8'h00;
         rw_r       <= 1'b0;
         O_SDA_OE_N <= 1'b1;
      end
      else if (I_CE)
      begin
         if (start_c)
         begin
            state_r    <= ST_ADDR; // R4
            O_SDA_OE_N <= 1'b1;
         end
         else if (stop_c)
         begin
            state_r    <= ST_IDLE; // R3
            O_SDA_OE_N <= 1'b1;
         end
         else
         begin
            case (state_r)
               ST_ADDR:
                  if (byte_end)
                  begin
                     if (shift_r[7:1] == my_addr)
                     begin
                        rw_r       <= shift_r[0]; // R6
                        O_SDA_OE_N <= 1'b0; // R8
                        state_r    <= ST_ADDR_ACK;
                     end
                     else
                        state_r <= ST_IGNORE; // R27
                  end
               ST_ADDR_ACK:
                  if (scl_fall)
                  begin
                     if (rw_r)
                     begin
                        tx_r       <= rd_byte; // R26
                        O_SDA_OE_N <= rd_byte[7];
                        state_r    <= ST_TX;
                     end
                     else
                     begin
                        O_SDA_OE_N <= 1'b1; // R5
                        state_r    <= ST_REG;
                     end
                  end
               ST_REG:
                  if (byte_end)
                  begin
                     ptr_r      <= shift_r; // R7
                     O_SDA_OE_N <= 1'b0; // R8
                     state_r    <= ST_REG_ACK;
                  end
               ST_DATA:
                  if (byte_end)
                  begin
                     O_SDA_OE_N <= 1'b0; // R8
                     state_r    <= ST_DATA_ACK;
                  end
               ST_REG_ACK, ST_DATA_ACK:
                  if (scl_fall)
                  begin
                     O_SDA_OE_N <= 1'b1;
                     state_r    <= ST_DATA;
                  end
               ST_TX:
                  if (byte_end)
                  begin
                     O_SDA_OE_N <= 1'b1; // R5
                     state_r    <= ST_TX_ACK;
                  end
                  else if (scl_fall)
                  begin
                     tx_r       <= {tx_r[6:0], 1'b0};
                     O_SDA_OE_N <= tx_r[6]; // R2
                  end
               ST_TX_ACK:
                  if (scl_rise && sda_s)
                     state_r <= ST_IGNORE; // R26
                  else if (scl_fall)
                  begin
                     tx_r       <= rd_byte;
                     O_SDA_OE_N <= rd_byte[7];
                     state_r    <= ST_TX;
                  end
               default:
                  state_r <= state_r;
            endcase
         end
      end
   end

   assign wr_commit  = (state_r == ST_DATA) && byte_end && !start_c && !stop_c; // R9
   assign ref_accept = wr_commit && (ptr_r == `VOLT_SEL_OFS) && ctrl_r[`UNLOCK_BIT];
   assign delta      = (shift_r[6:0] > volt_sel_r[6:0]) ?
                       7'(shift_r[6:0] - volt_sel_r[6:0]) :
                       7'(volt_sel_r[6:0] - shift_r[6:0]);

   always_ff @(posedge I_MCLK)
   begin
      if (clr)
      begin
         volt_sel_r <= `VOLT_SEL_RST;
         big_step_r <= 1'b0;
      end
      else if (I_CE)
      begin
         if (wr_commit && ptr_r == `VOLT_SEL_OFS)
            volt_sel_r[`LOOP_SEL_BIT] <= shift_r[`LOOP_SEL_BIT]; // R10
         if (ref_accept)
         begin
            volt_sel_r[`REF_CODE_HI:0] <= shift_r[`REF_CODE_HI:0]; // R13
            big_step_r <= delta > `SMALL_STEP_CODES; // R14
         end
         else if (ramp_done)
            big_step_r <= 1'b0;
      end
   end

   // a host write to control wins over the self-clear in the same cycle
   always_ff @(posedge I_MCLK)
   begin
      if (clr)
         ctrl_r <= `CTRL_RST;
      else if (I_CE)
      begin
         if (wr_commit && ptr_r == `CTRL_OFS)
            ctrl_r <= shift_r; // R9
         else if (ramp_done && big_step_r)
            ctrl_r[`UNLOCK_BIT] <= 1'b0; // R13
      end
   end

   always_ff @(posedge I_MCLK)
   begin
      if (I_SYS_RST)
         fault_r <= 8'h00;
      else if (I_CE)
         fault_r <= {3'h0, pins_s[4], pins_s[5], pins_s[6], // R19 R20 R21 R22
                     pins_s[7], pins_s[8]}; // R21 R23 R24
   end

   always_ff @(posedge I_MCLK)
   begin
      if (clr)
      begin
         O_CONVERTER_ON           <= 1'b0;
         O_SDA_OUT                <= 1'b0;
         O_DIVIDER_LOOP_SEL       <= 1'b1;
         O_SLEW_SEL               <= 3'h4;
         O_FREQ_SEL               <= 2'h0;
         O_FORCED_CONTINUOUS_MODE <= 1'b1;
      end
      else if (I_CE)
      begin
         O_CONVERTER_ON           <= ctrl_r[`CONV_ON_BIT]; // R12
         O_SDA_OUT                <= 1'b0;
         O_DIVIDER_LOOP_SEL       <= volt_sel_r[`LOOP_SEL_BIT]; // R10
         O_SLEW_SEL               <= ctrl_r[`SLEW_HI:`SLEW_LO]; // R15
         O_FREQ_SEL               <= ctrl_r[`FREQ_HI:`FREQ_LO]; // R16
         O_FORCED_CONTINUOUS_MODE <= ctrl_r[`MODE_BIT]; // R17
      end
   end

   ref_slew u_ref_slew (
      .i_clk      (I_MCLK),
      .i_rst      (clr),
      .i_ce       (I_CE),
      .i_target   (volt_sel_r[`REF_CODE_HI:0]), // R11
      .i_rate_sel (ctrl_r[`SLEW_HI:`SLEW_LO]),
      .o_code     (O_REF_CODE),
      .o_done     (ramp_done)
   );

   chk_start_restart: // R4
      assert property (@(posedge I_MCLK) disable iff (clr)
         I_CE && start_c |=> state_r == ST_ADDR && cnt_r == 4'h0)
      else $error("start did not restart address phase");

   chk_stop_idle: // R3
      assert property (@(posedge I_MCLK) disable iff (clr)
         I_CE && stop_c && !start_c |=> state_r == ST_IDLE && O_SDA_OE_N)
      else $error("stop did not free the bus");

   chk_addr_ack: // R8
      assert property (@(posedge I_MCLK) disable iff (clr)
         I_CE && state_r == ST_ADDR && byte_end && shift_r[7:1] == my_addr && !start_c
         && !stop_c |=> !O_SDA_OE_N && state_r == ST_ADDR_ACK)
      else $error("matching address not acknowledged");

   chk_nomatch_quiet: // R27
      assert property (@(posedge I_MCLK) disable iff (clr)
         state_r == ST_IGNORE |-> O_SDA_OE_N)
      else $error("sda driven after unmatched address");

   chk_sda_scl_low: // R2
      assert property (@(posedge I_MCLK) disable iff (clr)
         O_SDA_OE_N != $past(O_SDA_OE_N) && !$past(clr) |-> !scl_s)
      else $error("sda changed while scl high");

   chk_commit_fall: // R9
      assert property (@(posedge I_MCLK) disable iff (clr)
         I_CE && wr_commit && ptr_r == `CTRL_OFS |-> scl_fall ##1 ctrl_r == $past(shift_r))
      else $error("control write not committed at scl fall");

   chk_ref_locked: // R13
      assert property (@(posedge I_MCLK) disable iff (clr)
         volt_sel_r[6:0] != $past(volt_sel_r[6:0]) |-> $past(ctrl_r[`UNLOCK_BIT]))
      else $error("reference changed while locked");

   chk_small_step_keep: // R14
      assert property (@(posedge I_MCLK) disable iff (clr)
         I_CE && ramp_done && !big_step_r && !wr_commit |=> ctrl_r[`UNLOCK_BIT]
         == $past(ctrl_r[`UNLOCK_BIT]))
      else $error("unlock cleared after small step");

   chk_enable_off: // R12
      assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
         !en_s |=> !O_CONVERTER_ON && O_SDA_OE_N)
      else $error("converter or interface active with enable low");

   chk_reserved_zero: // R19
      assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
         fault_r[7:5] == 3'h0)
      else $error("reserved fault bits not zero");

endmodule : conv_i2c_ctrl

// file: verilog/conv_pkg.sv
package conv_pkg;

   typedef logic [7:0] byte_t;
   typedef logic [6:0] ref_code_t;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_REG,
      ST_REG_ACK,
      ST_DATA,
      ST_DATA_ACK,
      ST_TX,
      ST_TX_ACK,
      ST_IGNORE
   } link_state_e;

endpackage : conv_pkg

// file: verilog/ref_slew.sv
`timescale 1ns/10ps
`include "conv_defs.svh"
module ref_slew
   import conv_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic       i_ce,
   input  wire ref_code_t  i_target,
   input  wire logic [2:0] i_rate_sel,
   output ref_code_t       o_code,
   output logic            o_done
);

   logic [11:0] timer_r;
   logic [11:0] limit;
   ref_code_t   next;
   logic        step;

   // cycles per 10 mV step; rate table is 64 mV/us halved per code
   function automatic logic [11:0] step_cycles(input logic [2:0] sel);
      step_cycles = 12'(((`STEP_MV) * 2000000 / ((`SLEW_FASTEST_X2) >> sel))
                        / (`MCLK_PERIOD_PS));
   endfunction : step_cycles

   assign limit = step_cycles(i_rate_sel) - 12'h001;
   assign step  = (o_code != i_target) && (timer_r >= limit);
   assign next  = (i_target > o_code) ? 7'(o_code + 7'h01) : 7'(o_code - 7'h01);

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         timer_r <= 12'h000;
      else if (i_ce)
      begin
         if (o_code == i_target || step)
            timer_r <= 12'h000;
         else
            timer_r <= timer_r + 12'h001;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_code <= 7'h00;
         o_done <= 1'b0;
      end
      else if (i_ce)
      begin
         if (step)
            o_code <= next; // R25
         o_done <= step && (next == i_target);
      end
   end

   chk_ramp_unit_step: // R25
      assert property (@(posedge i_clk) disable iff (i_rst)
         o_code != $past(o_code) |->
            (o_code == 7'($past(o_code) + 7'h01)) || (o_code == 7'($past(o_code) - 7'h01)))
      else $error("reference moved by more than one code");

endmodule : ref_slew
